// >>> rtl/ipm_pkg.sv
// ************************************************************
// Shared constants for the input port power monitor
// ************************************************************
package ipm_pkg;

  // ************************************************************
  // Data widths
  // ************************************************************
  localparam int SAMPLE_W  = 16;
  localparam int MAG_W     = 15;
  localparam int POW_W     = 15;
  localparam int POW_SHIFT = 9;
  localparam int PWR6_W    = POW_W - POW_SHIFT;
  localparam int ACC_W     = 24;
  localparam int PERIOD_W  = 24;
  localparam int THR_W     = 10;
  localparam int EXP_W     = 4;
  localparam int MANT_W    = 20;
  localparam int MAX_SHIFT = 14;

  // ************************************************************
  // Register map: one block of four words per port, then globals
  // ************************************************************
  localparam int             ADDR_W         = 12;
  localparam logic [3:0]     OFF_CTRL       = 4'h0;
  localparam logic [3:0]     OFF_PERIOD     = 4'h4;
  localparam logic [3:0]     OFF_THRESH     = 4'h8;
  localparam logic [3:0]     OFF_HOLD       = 4'hC;
  localparam logic [11:0]    OFF_INT_STATUS = 12'h100;
  localparam logic [11:0]    OFF_INT_ENABLE = 12'h104;
  localparam logic [2:0]     HSIZE_WORD     = 3'h2;

  // ************************************************************
  // Control word fields and reset values
  // ************************************************************
  localparam int             CTRL_W         = 5;
  localparam int             CTRL_FSEL_LSB  = 0;
  localparam int             CTRL_DIS_BIT   = 2;
  localparam int             CTRL_COR_BIT   = 3;
  localparam int             CTRL_EN_BIT    = 4;
  localparam logic [4:0]     CTRL_RST       = 5'h00;
  localparam logic [23:0]    PERIOD_RST     = 24'h000001;
  localparam logic [9:0]     THRESH_RST     = 10'h3FF;
  localparam logic [23:0]    COUNT_ONE      = 24'h000001;

  // ************************************************************
  // Monitoring modes
  // ************************************************************
  typedef enum logic [2:0] {
    IPM_PEAK = 3'b001,
    IPM_MEAN = 3'b010,
    IPM_CNT  = 3'b100
  } ipm_mode_t;

  // Function select to mode; upper bit set means counting
  function automatic ipm_mode_t ipm_decode_mode(input logic [1:0] fsel);
    ipm_mode_t m;
    case (fsel)
      2'h0:    m = IPM_PEAK;
      2'h1:    m = IPM_MEAN;
      default: m = IPM_CNT;
    endcase
    return m;
  endfunction : ipm_decode_mode

endpackage : ipm_pkg

// >>> rtl/ipm_mag.sv
`timescale 1ns/1ps
// ************************************************************
// Sample magnitude and power, one register stage
// ************************************************************
module ipm_mag
  import ipm_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       ce,
  // Sample in
  input  wire logic signed [SAMPLE_W-1:0] sample,
  // Results
  output logic             [MAG_W-1:0]    mag,
  output logic             [POW_W-1:0]    power
);

  logic [SAMPLE_W-1:0] abs_v;
  logic [MAG_W-1:0]    mag_nxt;
  logic [2*MAG_W-1:0]  sq;

  // Most negative code has no positive twin, so it saturates
  assign abs_v   = sample[SAMPLE_W-1] ? (~sample + 16'h0001) : sample;
  assign mag_nxt = abs_v[SAMPLE_W-1] ? {MAG_W{1'b1}} : abs_v[MAG_W-1:0];
  assign sq      = mag_nxt * mag_nxt;

  // Register both results
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mag   <= '0;
      power <= '0;
    end
    else if (ce)
    begin
      mag   <= mag_nxt;
      power <= sq[2*MAG_W-1:MAG_W];
    end
  end

endmodule : ipm_mag

// >>> rtl/ipm_float.sv
`timescale 1ns/1ps
// ************************************************************
// Accumulator to exponent and mantissa
// ************************************************************
module ipm_float
  import ipm_pkg::*;
(
  // Raw accumulator
  input  wire logic [ACC_W-1:0] acc,
  // Exponent on top, mantissa below
  output logic      [ACC_W-1:0] fmt
);

  // Count of zeros above the leading one
  function automatic logic [4:0] lead_zeros(input logic [ACC_W-1:0] v);
    logic [4:0] n;
    n = 5'h18;
    for (int i = 0; i < ACC_W; i++)
    begin
      if (v[i])
      begin
        n = 5'(ACC_W - 1 - i);
      end
    end
    return n;
  endfunction : lead_zeros

  logic [4:0]       lz;
  logic [EXP_W-1:0] shift;
  logic [ACC_W-1:0] norm;

  // Shift is capped so the exponent fits four bits; tiny values are left unnormalised
  assign lz    = lead_zeros(acc);
  assign shift = (lz > 5'(MAX_SHIFT)) ? EXP_W'(MAX_SHIFT) : lz[EXP_W-1:0];
  assign norm  = acc << shift;
  assign fmt   = {shift + 4'h1, norm[ACC_W-1:ACC_W-MANT_W]};

endmodule : ipm_float

// >>> rtl/ipm_top.sv
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
// How it works
// - Function select 01 accumulates sample power over the period for mean power.
// - Starting a mode loads the period into a down-counter that counts each cycle.
// - Mean mode adds power shifted right nine (six bits) into a 24-bit store.
// - Timer at 1 copies the store, in float form for mean, into holding, then reloads the timer.
// - After a mean period end with timer enabled, the store is seeded with the first new sample power.
// - Every period end sets interrupt status and, if enabled, asserts the interrupt.
// - Mean result is float: 4-bit exponent on top, 20-bit mantissa below.
// - Function select with upper bit set means threshold crossing count mode.
// - Count mode uses the port's 10-bit upper threshold, programmed beforehand.
// - Count store starts at zero and adds one per cycle above threshold.
// - With timer enabled, count store clears to zero at each period end after the transfer.
// - With timer disabled, timer keeps counting but its end transfers nothing.
// - With timer disabled, a holding read transfers the store and reloads the timer.
// - With timer disabled, timer end still sets status and may interrupt.
// - Clear-on-read works only while the timer-disable bit is set.
// - Both bits set: read reseeds store with magnitude or power, zero when counting.
// - Clear-on-read off: read leaves the store and its running work untouched.
// - Select 00 is peak mode: store starts at magnitude and keeps the maximum.
// - Each port has its own 2-bit select and exactly one active mode.
module ipm_top
  import ipm_pkg::*;
#(
  parameter int NPORT = 4
)(
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       ce,
  // AHB-Lite slave
  input  wire logic                       hsel,
  input  wire logic        [31:0]         haddr,
  input  wire logic        [1:0]          htrans,
  input  wire logic                       hwrite,
  input  wire logic        [2:0]          hsize,
  input  wire logic        [31:0]         hwdata,
  input  wire logic                       hready,
  output logic             [31:0]         hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  // Input port samples
  input  wire logic signed [SAMPLE_W-1:0] sample_in [NPORT],
  // Interrupt pin
  output logic                            interrupt_request_pin_n
);

  // Port index width inside the per-port address blocks
  localparam int PIDX_W = $clog2(NPORT);

  // ************************************************************
  // Bus decode
  // ************************************************************

  // Address matches one register of port p
  function automatic logic port_hit(input logic [ADDR_W-1:0] a, input int p, input logic [3:0] off);
    return (a[ADDR_W-1:4] == 8'(p)) && (a[3:0] == off);
  endfunction : port_hit

  logic              wr_pend_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [NPORT-1:0]  int_stat_r;
  logic [NPORT-1:0]  int_en_r;
  logic [NPORT-1:0]  tick_evt;
  logic [NPORT-1:0]  int_stat_nxt;
  logic [31:0]       port_word [NPORT];

  wire [ADDR_W-1:0] ra          = haddr[ADDR_W-1:0];
  wire              addr_take   = hsel & htrans[1] & hready & (hsize == HSIZE_WORD);
  wire              rd_take     = addr_take & ~hwrite;
  wire              wr_take     = addr_take & hwrite;
  wire              port_idx_ok = ra[ADDR_W-1:4] < 8'(NPORT);
  wire              wr_stat     = wr_pend_r & (wr_addr_r == OFF_INT_STATUS);
  wire              wr_ien      = wr_pend_r & (wr_addr_r == OFF_INT_ENABLE);

  // Limitation: a read placed right behind a write to the same word
  // returns the old value, because the write lands at that same edge
  // Read mux; other offsets in a port block read its holding word, other unmapped addresses read as zero
  wire [31:0] rd_word = (ra == OFF_INT_STATUS) ? 32'(int_stat_r) :
                        (ra == OFF_INT_ENABLE) ? 32'(int_en_r) :
                        port_idx_ok            ? port_word[ra[PIDX_W+3:4]] : 32'h00000000;

  // ************************************************************
  // Bus response registers
  // ************************************************************

  // Address phase capture; zero wait states so hreadyout stays high
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else if (ce)
    begin
      wr_pend_r <= wr_take;
      wr_addr_r <= wr_take ? ra : wr_addr_r;
      hrdata    <= rd_take ? rd_word : hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ************************************************************
  // One monitor per input port
  // ************************************************************
  // Ports share only the bus; each decodes its own four words
  // per-port instances
  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    logic      [CTRL_W-1:0]   ctrl_r;
    logic      [PERIOD_W-1:0] period_r;
    logic      [PERIOD_W-1:0] timer_r;
    logic      [THR_W-1:0]    thresh_r;
    logic      [ACC_W-1:0]    msr_r;
    logic      [ACC_W-1:0]    hold_r;
    logic      [MAG_W-1:0]    mag;
    logic      [POW_W-1:0]    pow;
    logic      [ACC_W-1:0]    fmt;
    ipm_mode_t                mode;
    ipm_mode_t                seed_mode;

    ipm_mag u_mag (
      .clk    (clk),
      .rst_n  (rst_n),
      .ce     (ce),
      .sample (sample_in[p]),
      .mag    (mag),
      .power  (pow)
    );

    ipm_float u_float (
      .acc (msr_r),
      .fmt (fmt)
    );

    // ************************************************************
    // Mode and control fields
    // ************************************************************

    assign mode = ipm_decode_mode(ctrl_r[CTRL_FSEL_LSB+1:CTRL_FSEL_LSB]);

    // Control bits and register strobes of this port
    wire en      = ctrl_r[CTRL_EN_BIT];
    wire dis     = ctrl_r[CTRL_DIS_BIT];
    wire cor     = ctrl_r[CTRL_COR_BIT];
    wire wr_ctrl = wr_pend_r & port_hit(wr_addr_r, p, OFF_CTRL);
    wire wr_per  = wr_pend_r & port_hit(wr_addr_r, p, OFF_PERIOD);
    wire wr_thr  = wr_pend_r & port_hit(wr_addr_r, p, OFF_THRESH);
    wire hold_rd = en & rd_take & port_hit(ra, p, OFF_HOLD);

    // a control write seeds for the mode that it writes, not the old one
    // so a switch from peak to counting does not start from a stale magnitude
    assign seed_mode = wr_ctrl ? ipm_decode_mode(hwdata[CTRL_FSEL_LSB+1:CTRL_FSEL_LSB]) : mode;

    // ************************************************************
    // Sample datapath
    // ************************************************************

    wire [PWR6_W-1:0] pwr6 = pow[POW_W-1:POW_SHIFT];
    // compare top magnitude bits to threshold
    wire              over = mag[MAG_W-1:MAG_W-THR_W] > thresh_r;

    // ************************************************************
    // Period timer and transfer strobes
    // ************************************************************

    // A period of zero acts as one, since the end test is at or below one
    // timer end at count of one
    wire tick_end = en & (timer_r <= COUNT_ONE);
    // timer end transfers only when enabled
    wire xfer_tmr = tick_end & ~dis;
    wire xfer_rd  = hold_rd & dis;
    wire clr_rd   = xfer_rd & cor;

    // load period on start and reload after each end or read transfer
    wire reload = wr_ctrl | tick_end | xfer_rd;
    // without clear-on-read a read does not reseed
    wire reseed = wr_ctrl | xfer_tmr | clr_rd;

    // mean mode returns the float form
    wire [ACC_W-1:0] hold_src = (mode == IPM_MEAN) ? fmt : msr_r;

    // ************************************************************
    // Storage seed and step
    // ************************************************************

    wire [ACC_W-1:0] seed = (seed_mode == IPM_PEAK) ? ACC_W'(mag) :
                            (seed_mode == IPM_MEAN) ? ACC_W'(pwr6) : '0;

    wire [ACC_W-1:0] add_in = (mode == IPM_MEAN) ? ACC_W'(pwr6) : ACC_W'(over);
    wire [ACC_W:0]   sum    = {1'b0, msr_r} + {1'b0, add_in};
    // Saturate rather than wrap, so an overlong period reads full scale
    wire [ACC_W-1:0] sum_s  = sum[ACC_W] ? {ACC_W{1'b1}} : sum[ACC_W-1:0];

    wire [ACC_W-1:0] step = (mode == IPM_PEAK) ? ((ACC_W'(mag) > msr_r) ? ACC_W'(mag) : msr_r) : sum_s;

    // ************************************************************
    // Next state
    // ************************************************************
    // Reseed beats the step; enable low holds store and timer except on a control write
    wire [ACC_W-1:0]    msr_nxt   = reseed ? seed : (en ? step : msr_r);
    wire [PERIOD_W-1:0] timer_nxt = reload ? period_r : (en ? timer_r - COUNT_ONE : timer_r);
    wire [ACC_W-1:0]    hold_nxt  = (xfer_tmr | xfer_rd) ? hold_src : hold_r;

    // Holding word shows the value a read would transfer when reads drive it
    wire [31:0] hold_view = (en & dis) ? 32'(hold_src) : 32'(hold_r);

    assign port_word[p] = (ra[3:0] == OFF_CTRL)   ? 32'(ctrl_r)   :
                          (ra[3:0] == OFF_PERIOD) ? 32'(period_r) :
                          (ra[3:0] == OFF_THRESH) ? 32'(thresh_r) : hold_view;

    assign tick_evt[p] = tick_end;

    // ************************************************************
    // Registers of this port
    // ************************************************************

    // Software-written control words
    // period must be in place before the control write
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        ctrl_r   <= CTRL_RST;
        period_r <= PERIOD_RST;
        thresh_r <= THRESH_RST;
      end
      else if (ce)
      begin
        ctrl_r   <= wr_ctrl ? hwdata[CTRL_W-1:0] : ctrl_r;
        period_r <= wr_per ? hwdata[PERIOD_W-1:0] : period_r;
        thresh_r <= wr_thr ? hwdata[THR_W-1:0] : thresh_r;
      end
    end

    // Monitor state
    // Clock enable low holds all three; samples in those cycles are not seen
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        timer_r <= PERIOD_RST;
        msr_r   <= '0;
        hold_r  <= '0;
      end
      else if (ce)
      begin
        timer_r <= timer_nxt;
        msr_r   <= msr_nxt;
        hold_r  <= hold_nxt;
      end
    end
  end

  // ************************************************************
  // Interrupt status, enable and pin
  // ************************************************************

  // Status bits stay set until software writes ones to clear them;
  // a period end in the clearing cycle wins, so no event is lost
  // sticky status, set beats write-one-to-clear
  assign int_stat_nxt = (int_stat_r & ~(wr_stat ? hwdata[NPORT-1:0] : '0)) | tick_evt;

  // Pin follows the new status so it moves on the same edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_stat_r              <= '0;
      int_en_r                <= '0;
      interrupt_request_pin_n <= 1'b1;
    end
    else if (ce)
    begin
      int_stat_r              <= int_stat_nxt;
      int_en_r                <= wr_ien ? hwdata[NPORT-1:0] : int_en_r;
      interrupt_request_pin_n <= ~|(int_stat_nxt & int_en_r);
    end
  end

endmodule : ipm_top

// >>> verif/ipm_asserts.sv
`timescale 1ns/1ps
// ************************************************************
// Port-level checks on bus, interrupt pin and clock enable
// ************************************************************
module ipm_asserts
  import ipm_pkg::*;
#(
  parameter int NPORT = 4
)(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Interrupt
  input wire logic        interrupt_request_pin_n
);
  logic             wr_q;
  logic [11:0]      a_q;
  logic [NPORT-1:0] ena_sh;
  // Accepted address phase
  wire logic take = ce && hsel && htrans[1] && hready && hsize == HSIZE_WORD;
  wire logic rd_t = take && !hwrite;

  // Shadow of the enable word; written at the data-phase edge like the slave
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      wr_q   <= 1'b0;
      a_q    <= 12'h000;
      ena_sh <= '0;
    end
    else if (ce)
    begin
      wr_q <= take && hwrite;
      a_q  <= haddr[11:0];
      if (wr_q && a_q == OFF_INT_ENABLE)
        ena_sh <= hwdata[NPORT-1:0];
    end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("error response seen");
  a_reset_idle: assert property ($rose(rst_n) |-> interrupt_request_pin_n && hrdata == 32'h0)
    else $error("outputs not idle after reset");
  a_unmapped_zero: assert property (rd_t && haddr[11:0] == 12'h200 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_read_stands: assert property (!rd_t |=> $stable(hrdata)) else $error("read data moved");
  a_enable_read: assert property (rd_t && !wr_q && haddr[11:0] == OFF_INT_ENABLE |=> hrdata == 32'(ena_sh))
    else $error("enable readback wrong");
  a_irq_masked: assert property (ena_sh == '0 && $past(ena_sh) == '0 |-> interrupt_request_pin_n)
    else $error("interrupt while masked");
  a_ce_freeze: assert property (!ce |=> $stable(hrdata) && $stable(interrupt_request_pin_n))
    else $error("outputs moved with clock enable low");
endmodule : ipm_asserts

bind ipm_top ipm_asserts #(.NPORT(NPORT)) u_asserts (.clk, .rst_n, .ce, .hsel, .haddr, .htrans, .hwrite,
  .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .interrupt_request_pin_n);

// >>> verif/ipm_host.sv
`timescale 1ns/1ps
// ************************************************************
// Bus master standing in for the host processor
// ************************************************************
module ipm_host
  import ipm_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Master outputs
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  // Slave answer
  input  wire logic [31:0] hrdata,
  input  wire logic        hreadyout
);
  // Idle bus from time zero
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = HSIZE_WORD;
    hwdata = 32'h0;
  end

  // One word transfer; waits for ready rather than assuming a latency
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {20'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    haddr  <= ~haddr;
    hwdata <= w ? d : ~hwdata;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer
endmodule : ipm_host

// >>> verif/tb_top.sv
`timescale 1ns/1ps
// ************************************************************
// Self-checking bench for the port monitor
// ************************************************************
module tb_top;
  import ipm_pkg::*;
  logic                       clk, rst_n, ce, hsel, hwrite, hreadyout, hresp, irq_n;
  logic [1:0]                 htrans;
  logic [2:0]                 hsize;
  logic [31:0]                haddr, hwdata, hrdata, q, q1;
  logic signed [SAMPLE_W-1:0] smp [4];
  logic [15:0]                v0, v1;
  logic [11:0]                ra [7];
  logic [31:0]                re [7];
  int                         n_fail, total_checks, cyc, n;

  // 40 MHz clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  ipm_top #(.NPORT(4)) dut (.clk, .rst_n, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sample_in(smp), .interrupt_request_pin_n(irq_n));
  ipm_host host (.clk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hrdata, .hreadyout);

  // Magnitude saturates: the most negative code would not fit 15 bits
  function automatic logic [14:0] mag_of(input logic [15:0] v);
    logic [15:0] a;
    a = v[15] ? -v : v;
    return a[15] ? 15'h7FFF : a[14:0];
  endfunction : mag_of

  // Constant input: k samples of power shifted down to six bits
  function automatic logic [23:0] mean_of(input logic [15:0] v, input int k);
    logic [29:0] p;
    p = mag_of(v) * mag_of(v);
    return 24'(k * int'(p[29:24]));
  endfunction : mean_of

  // Normalise: exponent on top, mantissa below
  function automatic logic [23:0] fmt_of(input logic [23:0] a);
    int          s;
    logic [23:0] t;
    s = 0;
    while (s < 14 && !a[23-s])
      s++;
    t = a << s;
    return {4'(s + 1), t[23:4]};
  endfunction : fmt_of

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, q1);
    chk("hrdata", e, q1);
  endtask : rchk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // Hang guard, well above the expected run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_fail++;
      end_sim();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    smp = '{default: 16'h0};
    ra = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h100, 12'h104, 12'h200};
    re = '{32'h0, 32'h1, 32'h3FF, 32'h0, 32'h0, 32'h0, 32'h0};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    q = $urandom(58692);
    // Reset values, then an unmapped word
    for (int i = 0; i < 7; i++)
      rchk(ra[i], re[i]);
    $display("test reset done");
    // Mean on port 0, peak on 1, counting above and below threshold on 2 and 3
    for (int i = 0; i < 2; i++)
    begin
      v0 = 16'($urandom);
      v1 = 16'($urandom);
      n = 4 + int'($urandom % 13);
      smp <= '{v0, v1, 16'hC000, 16'h0010};
      for (int p = 0; p < 4; p++)
      begin
        wr(12'(p * 16 + 4), 32'(n));
        wr(12'(p * 16 + 8), 32'h1FF);
      end
      wr(12'h000, 32'h11);
      wr(12'h010, 32'h10);
      wr(12'h020, 32'h12);
      wr(12'h030, 32'h13);
      repeat (3 * n + 10) @(posedge clk);
      rchk(12'h00C, {8'h0, fmt_of(mean_of(v0, n))});
      rchk(12'h01C, 32'(mag_of(v1)));
      rchk(12'h02C, 32'(n - 1));
      rchk(12'h03C, 32'h0);
    end
    $display("test modes done");
    // Interrupt raised, then masked and cleared
    wr(12'h104, 32'hF);
    repeat (n + 4) @(posedge clk);
    chk("irq_n", 32'h0, 32'(irq_n));
    rchk(12'h100, 32'hF);
    wr(12'h104, 32'h0);
    wr(12'h100, 32'hF);
    repeat (2) @(posedge clk);
    chk("irq_n", 32'h1, 32'(irq_n));
    $display("test interrupt done");
    // Clear-on-read alone must not disturb the periodic count
    wr(12'h020, 32'h1A);
    repeat (2 * n + 4) @(posedge clk);
    rchk(12'h02C, 32'(n - 1));
    repeat (n + 2) @(posedge clk);
    rchk(12'h02C, 32'(n - 1));
    // Timer disabled: store keeps growing past the period
    wr(12'h100, 32'hF);
    wr(12'h020, 32'h16);
    repeat (100) @(posedge clk);
    host.xfer(1'b0, 12'h02C, 32'h0, q1);
    chk("grow", 32'h1, 32'(q1 > 32'(n)));
    host.xfer(1'b0, 12'h100, 32'h0, q);
    chk("status", 32'h1, 32'(q[2]));
    host.xfer(1'b0, 12'h02C, 32'h0, q);
    chk("keep", 32'h1, 32'(q > q1));
    // Peak to counting with the threshold out of reach: the count must start at zero
    wr(12'h018, 32'h3FF);
    wr(12'h010, 32'h16);
    rchk(12'h01C, 32'h0);
    // Both bits set: a read restarts the count from zero
    wr(12'h020, 32'h1E);
    repeat (50) @(posedge clk);
    host.xfer(1'b0, 12'h02C, 32'h0, q1);
    host.xfer(1'b0, 12'h02C, 32'h0, q);
    chk("clear", 32'h1, 32'(q < 32'd8 && q1 > 32'd40));
    $display("test disabled timer done");
    // Clock enable held low for a few cycles
    ce <= 1'b0;
    repeat (5) @(posedge clk);
    ce <= 1'b1;
    wr(12'h104, 32'h5);
    rchk(12'h104, 32'h5);
    $display("test clock enable done");
    end_sim();
  end
endmodule : tb_top
